// [dec_capture.sv]
// Dual edge capture of one input pin with APB configuration and status.
// Assumes the pin, enable and force inputs are synchronous to CLK_I, and
// that software writes the configuration while the capture is idle.
`timescale 1ns/1ps
module dec_capture
  import dec_pkg::*;
(
  input  wire logic        CLK_I,      // System clock, 10 MHz
  input  wire logic        SYS_RST_I,  // Asynchronous reset, active high
  input  wire logic        PSEL_I,     // APB select
  input  wire logic        PENABLE_I,  // APB enable
  input  wire logic        PWRITE_I,   // APB write
  input  wire logic [7:0]  PADDR_I,    // APB byte address
  input  wire logic [31:0] PWDATA_I,   // APB write data
  output logic      [31:0] PRDATA_O,   // APB read data
  output logic             PREADY_O,   // APB ready
  output logic             PSLVERR_O,  // APB error on unmapped address
  input  wire logic        DATA_I,     // Receiver output of the pin
  input  wire logic        CE_I,       // Shared clock enable
  input  wire logic        SR_I,       // Primary reset input
  input  wire logic        REV_I,      // Reverse force input
  output logic             RISE_O,     // Rising edge sample
  output logic             FALL_O,     // Falling edge sample
  output logic             COMB_O      // Unregistered bypass of the pin
);

  // ****************************************************
  // APB slave
  // ****************************************************
  logic [DEC_CFG_W-1:0] cfg_r;
  logic                 pready_r;
  logic                 pslverr_r;
  logic [31:0]          prdata_r;
  logic                 addr_ok;
  logic                 acc_done;
  logic [31:0]          stat_word;

  assign addr_ok   = (PADDR_I == DEC_CFG_ADDR) || (PADDR_I == DEC_STAT_ADDR);
  assign acc_done  = PSEL_I && PENABLE_I && pready_r;

  always_ff @(posedge CLK_I or posedge SYS_RST_I) begin
    if (SYS_RST_I) begin
      pready_r  <= 1'b0;
      pslverr_r <= 1'b0;
      prdata_r  <= 32'h0000_0000;
    end else begin
      pready_r  <= PSEL_I && !PENABLE_I;
      pslverr_r <= PSEL_I && !PENABLE_I && !addr_ok;
      if (PSEL_I && !PENABLE_I && !PWRITE_I) begin
        if (PADDR_I == DEC_CFG_ADDR) begin
          prdata_r <= {18'h0_0000, cfg_r};
        end else if (PADDR_I == DEC_STAT_ADDR) begin
          prdata_r <= stat_word;
        end else begin
          prdata_r <= 32'h0000_0000;
        end
      end
    end
  end

  // Configuration is held static while capturing; defaults give
  // opposite-edge mode and synchronous forces.
  always_ff @(posedge CLK_I or posedge SYS_RST_I) begin
    if (SYS_RST_I) begin
      cfg_r <= DEC_CFG_RST;
    end else if (acc_done && PWRITE_I && (PADDR_I == DEC_CFG_ADDR)) begin
      cfg_r <= PWDATA_I[DEC_CFG_W-1:0];
    end
  end

  assign PRDATA_O  = prdata_r;
  assign PREADY_O  = pready_r;
  assign PSLVERR_O = pslverr_r;

  // ****************************************************
  // Configuration decode and control polarity
  // ****************************************************
  dec_mode_t  mode;
  logic       async_f;
  logic [3:0] reset_value_attr;
  logic       latch_f;
  logic       ce_eff;
  logic       sr_eff;
  logic       rev_eff;
  logic       force_on;
  logic       init_pend_r;

  assign mode     = dec_mode_t'(cfg_r[DEC_MODE_LSB +: 2]);
  assign async_f  = cfg_r[DEC_ASYNC_BIT];
  assign reset_value_attr    = cfg_r[DEC_RESET_VALUE_ATTR_LSB +: 4];
  assign latch_f  = cfg_r[DEC_LATCH_BIT];
  assign sr_eff   = SR_I ^ cfg_r[DEC_SR_INV];
  assign rev_eff  = REV_I ^ cfg_r[DEC_REV_INV];
  // An enable that is not wired in reads as asserted.
  assign ce_eff   = cfg_r[DEC_CE_USED] ? (CE_I ^ cfg_r[DEC_CE_INV]) : 1'b1;
  assign force_on = sr_eff || rev_eff;

  // Value a forced element takes, from its reset value bit.
  function automatic logic force_val(input logic sv, input logic sr, input logic reverse_force_in);
    logic v;
    v = 1'b0;
    if (sr && reverse_force_in) begin
      v = 1'b0;
    end else if (sr) begin
      v = sv;
    end else if (reverse_force_in) begin
      v = !sv;
    end
    return v;
  endfunction

  // A synchronous force waits for the enable; an asynchronous one acts
  // at the element's next edge whatever the enable says.
  logic take_force;
  logic take_data;
  assign take_force = force_on && (async_f || ce_eff);
  assign take_data  = !force_on && ce_eff;

  // Initial values are applied at the first edge after reset release.
  always_ff @(posedge CLK_I or posedge SYS_RST_I) begin
    if (SYS_RST_I) begin
      init_pend_r <= 1'b1;
    end else begin
      init_pend_r <= 1'b0;
    end
  end

  // ****************************************************
  // Storage elements
  // ****************************************************
  logic clk_n;
  logic first_capture_reg;
  logic falling_capture_reg;
  logic same_edge_retime_reg;
  logic [1:0] pipeline_align_reg;

  assign clk_n = ~CLK_I;

  // First element; as a latch it holds what it saw when the clock fell.
  always_ff @(posedge CLK_I or posedge SYS_RST_I) begin
    if (SYS_RST_I) begin
      first_capture_reg <= 1'b0;
    end else if (init_pend_r) begin
      first_capture_reg <= cfg_r[DEC_INIT_RISE];
    end else if (take_force) begin
      first_capture_reg <= force_val(reset_value_attr[DEC_EL_FIRST], sr_eff, rev_eff);
    end else if (take_data) begin
      first_capture_reg <= latch_f ? falling_capture_reg : DATA_I;
    end
  end

  // Falling element on the inverted copy of the one clock.
  always_ff @(posedge clk_n or posedge SYS_RST_I) begin
    if (SYS_RST_I) begin
      falling_capture_reg <= 1'b0;
    end else if (init_pend_r) begin
      falling_capture_reg <= cfg_r[DEC_INIT_FALL];
    end else if (take_force) begin
      falling_capture_reg <= force_val(reset_value_attr[DEC_EL_FALL], sr_eff, rev_eff);
    end else if (take_data) begin
      falling_capture_reg <= DATA_I;
    end
  end

  // Retime of the falling sample onto the rising edge.
  always_ff @(posedge CLK_I or posedge SYS_RST_I) begin
    if (SYS_RST_I) begin
      same_edge_retime_reg <= 1'b0;
    end else if (init_pend_r) begin
      same_edge_retime_reg <= cfg_r[DEC_INIT_FALL];
    end else if (take_force) begin
      same_edge_retime_reg <= force_val(reset_value_attr[DEC_EL_RETIME], sr_eff, rev_eff);
    end else if (take_data) begin
      same_edge_retime_reg <= falling_capture_reg;
    end
  end

  // Pipeline stage after both capture paths.
  always_ff @(posedge CLK_I or posedge SYS_RST_I) begin
    if (SYS_RST_I) begin
      pipeline_align_reg <= 2'h0;
    end else if (init_pend_r) begin
      pipeline_align_reg <= {cfg_r[DEC_INIT_FALL], cfg_r[DEC_INIT_RISE]};
    end else if (take_force) begin
      pipeline_align_reg <= {2{force_val(reset_value_attr[DEC_EL_PIPE], sr_eff, rev_eff)}};
    end else if (take_data) begin
      pipeline_align_reg <= {falling_capture_reg, first_capture_reg};
    end
  end

  // ****************************************************
  // Output selection
  // ****************************************************
  always_comb begin
    case (mode)
      DEC_OPPOSITE_EDGE: begin
        RISE_O = first_capture_reg;
        FALL_O = falling_capture_reg;
      end
      DEC_RISING_ALIGN: begin
        RISE_O = first_capture_reg;
        FALL_O = same_edge_retime_reg;
      end
      DEC_RISING_ALIGN_PIPED_MODE: begin
        RISE_O = pipeline_align_reg[0];
        FALL_O = pipeline_align_reg[1];
      end
      default: begin
        RISE_O = first_capture_reg;
        FALL_O = falling_capture_reg;
      end
    endcase
  end

  assign COMB_O    = DATA_I;
  assign stat_word = {26'h000_0000, ce_eff, init_pend_r, DATA_I, FALL_O, RISE_O, 1'b0};

  // ****************************************************
  // Assertions
  // ****************************************************
  logic quiet;
  assign quiet = take_data && !init_pend_r;

  sequence s_quiet2;
    quiet ##1 quiet;
  endsequence

  a_opp_rise_path: assert property (@(posedge CLK_I) disable iff (SYS_RST_I)
    (mode == DEC_OPPOSITE_EDGE) && quiet && !latch_f |=> RISE_O == $past(DATA_I))
    else $error("Rise output does not follow the pin.");

  a_same_retime: assert property (@(posedge CLK_I) disable iff (SYS_RST_I)
    quiet |=> same_edge_retime_reg == $past(falling_capture_reg))
    else $error("Retime stage missed the falling sample.");

  a_same_skew: assert property (@(posedge CLK_I) disable iff (SYS_RST_I)
    (mode == DEC_RISING_ALIGN) && quiet |=> FALL_O == $past(falling_capture_reg))
    else $error("Rising-align fall output is not one cycle behind.");

  a_piped_latency: assert property (@(posedge CLK_I) disable iff (SYS_RST_I)
    s_quiet2 ##0 ((mode == DEC_RISING_ALIGN_PIPED_MODE) && !latch_f)
    |=> RISE_O == $past(DATA_I, 2))
    else $error("Piped rise output latency is not two cycles.");

  a_piped_pair: assert property (@(posedge CLK_I) disable iff (SYS_RST_I)
    (mode == DEC_RISING_ALIGN_PIPED_MODE) && quiet
    |=> FALL_O == $past(falling_capture_reg))
    else $error("Piped pair not presented together.");

  a_ce_hold: assert property (@(posedge CLK_I) disable iff (SYS_RST_I)
    !ce_eff && !take_force && !init_pend_r
    |=> $stable(first_capture_reg) && $stable(same_edge_retime_reg))
    else $error("Element loaded while the enable was low.");

  a_ce_unused: assert property (@(posedge CLK_I) disable iff (SYS_RST_I)
    !cfg_r[DEC_CE_USED] |-> ce_eff)
    else $error("Unwired enable did not read as asserted.");

  a_both_reset: assert property (@(posedge CLK_I) disable iff (SYS_RST_I)
    sr_eff && rev_eff && ce_eff && !init_pend_r |=> !first_capture_reg && !RISE_O)
    else $error("Set won over reset.");

  a_srval1_set: assert property (@(posedge CLK_I) disable iff (SYS_RST_I)
    reset_value_attr[DEC_EL_FIRST] && sr_eff && !rev_eff && ce_eff && !init_pend_r
    |=> first_capture_reg)
    else $error("Primary reset did not set with reset value one.");

  a_srval0_rev: assert property (@(posedge CLK_I) disable iff (SYS_RST_I)
    !reset_value_attr[DEC_EL_FIRST] && !sr_eff && rev_eff && ce_eff && !init_pend_r
    |=> first_capture_reg)
    else $error("Reverse did not set with reset value zero.");

  a_async_force: assert property (@(posedge CLK_I) disable iff (SYS_RST_I)
    async_f && sr_eff && !rev_eff && !ce_eff && !init_pend_r
    |=> first_capture_reg == reset_value_attr[DEC_EL_FIRST])
    else $error("Asynchronous force waited for the enable.");

  a_init_value: assert property (@(posedge CLK_I) disable iff (SYS_RST_I)
    init_pend_r |=> first_capture_reg == $past(cfg_r[DEC_INIT_RISE]))
    else $error("Rise initial value not applied.");

  a_fall_path: assert property (@(posedge clk_n) disable iff (SYS_RST_I)
    take_data && !init_pend_r
    |=> falling_capture_reg == $past(DATA_I))
    else $error("Fall element missed the pin on the falling edge.");

  a_rise_sync: assert property (@(posedge CLK_I) disable iff (SYS_RST_I)
    !async_f && sr_eff && !rev_eff && ce_eff && !init_pend_r
    |=> first_capture_reg == $past(reset_value_attr[DEC_EL_FIRST]))
    else $error("Synchronous force missed the rise element.");

  a_fall_sync: assert property (@(posedge clk_n) disable iff (SYS_RST_I)
    !async_f && sr_eff && !rev_eff && ce_eff && !init_pend_r
    |=> falling_capture_reg == $past(reset_value_attr[DEC_EL_FALL]))
    else $error("Synchronous force missed the fall element.");

  a_fall_hold: assert property (@(posedge clk_n) disable iff (SYS_RST_I)
    !ce_eff && !take_force && !init_pend_r
    |=> $stable(falling_capture_reg))
    else $error("Fall element loaded while the enable was low.");

  a_fall_async: assert property (@(posedge clk_n) disable iff (SYS_RST_I)
    async_f && sr_eff && !rev_eff && !ce_eff && !init_pend_r
    |=> falling_capture_reg == $past(reset_value_attr[DEC_EL_FALL]))
    else $error("Asynchronous force on the fall element waited.");

  a_srval0_sr: assert property (@(posedge CLK_I) disable iff (SYS_RST_I)
    !reset_value_attr[DEC_EL_FIRST] && sr_eff && !rev_eff && ce_eff && !init_pend_r
    |=> !first_capture_reg)
    else $error("Primary reset did not clear with reset value zero.");

  a_srval1_rev: assert property (@(posedge CLK_I) disable iff (SYS_RST_I)
    reset_value_attr[DEC_EL_FIRST] && !sr_eff && rev_eff && ce_eff && !init_pend_r
    |=> !first_capture_reg)
    else $error("Reverse did not clear with reset value one.");

  a_latch_first: assert property (@(posedge CLK_I) disable iff (SYS_RST_I)
    latch_f && quiet
    |=> first_capture_reg == $past(falling_capture_reg))
    else $error("Latch mode did not hold the falling-edge value.");

  a_elem_reset_value_attr: assert property (@(posedge CLK_I) disable iff (SYS_RST_I)
    sr_eff && !rev_eff && take_force && !init_pend_r
    |=> same_edge_retime_reg == $past(reset_value_attr[DEC_EL_RETIME])
        && pipeline_align_reg == {2{$past(reset_value_attr[DEC_EL_PIPE])}})
    else $error("Element did not take its own reset value.");

  // ****************************************************
  // Bus assertions
  // ****************************************************

  a_apb_ready: assert property (@(posedge CLK_I) disable iff (SYS_RST_I)
    PSEL_I && !PENABLE_I
    |=> PREADY_O)
    else $error("Ready missing in the access cycle.");

  a_apb_once: assert property (@(posedge CLK_I) disable iff (SYS_RST_I)
    PREADY_O
    |=> !PREADY_O)
    else $error("Ready stood for more than one cycle.");

  a_apb_err: assert property (@(posedge CLK_I) disable iff (SYS_RST_I)
    PSEL_I && !PENABLE_I && !addr_ok
    |=> PSLVERR_O)
    else $error("Unmapped address gave no error.");

  a_cfg_write: assert property (@(posedge CLK_I) disable iff (SYS_RST_I)
    acc_done && PWRITE_I && (PADDR_I == DEC_CFG_ADDR)
    |=> cfg_r == $past(PWDATA_I[DEC_CFG_W-1:0]))
    else $error("Configuration write did not land.");

  a_stat_ro: assert property (@(posedge CLK_I) disable iff (SYS_RST_I)
    acc_done && PWRITE_I && (PADDR_I == DEC_STAT_ADDR)
    |=> $stable(cfg_r))
    else $error("Status write changed the configuration.");

endmodule

// [dec_pkg.sv]
// Constants for the dual edge capture block: register map, field layout and resets.
// Assumes a 32-bit APB with byte addresses and one word per register.
package dec_pkg;
  // ****************************************************
  // Register map
  // ****************************************************
  localparam logic [7:0]  DEC_CFG_ADDR     = 8'h00;
  localparam logic [7:0]  DEC_STAT_ADDR    = 8'h04;
  // ****************************************************
  // Configuration fields
  // ****************************************************
  localparam int          DEC_MODE_LSB     = 0;
  localparam int          DEC_ASYNC_BIT    = 2;
  localparam int          DEC_RESET_VALUE_ATTR_LSB    = 3;
  localparam int          DEC_LATCH_BIT    = 7;
  localparam int          DEC_INIT_RISE    = 8;
  localparam int          DEC_INIT_FALL    = 9;
  localparam int          DEC_CE_INV       = 10;
  localparam int          DEC_SR_INV       = 11;
  localparam int          DEC_REV_INV      = 12;
  localparam int          DEC_CE_USED      = 13;
  localparam int          DEC_CFG_W        = 14;
  localparam logic [13:0] DEC_CFG_RST      = 14'h2000;
  // ****************************************************
  // Storage element indices into the reset value field
  // ****************************************************
  localparam int          DEC_EL_FIRST     = 0;
  localparam int          DEC_EL_FALL      = 1;
  localparam int          DEC_EL_PIPE      = 2;
  localparam int          DEC_EL_RETIME    = 3;
  // ****************************************************
  // Alignment modes
  // ****************************************************
  typedef enum logic [1:0] {
    DEC_OPPOSITE_EDGE,
    DEC_RISING_ALIGN,
    DEC_RISING_ALIGN_PIPED_MODE,
    DEC_MODE_SPARE
  } dec_mode_t;
endpackage

// [dec_sink.sv]
// Partner model: the fabric logic that takes each captured sample pair.
// Assumes the pair is settled at every rising edge of the system clock.
`timescale 1ns/1ps
module dec_sink (
  input  wire logic clk_i,   // System clock
  input  wire logic rise_i,  // Rising sample from the capture
  input  wire logic fall_i,  // Falling sample from the capture
  output logic      rise_o,  // Rising sample taken at the last edge
  output logic      fall_o   // Falling sample taken at the last edge
);
  always_ff @(posedge clk_i) begin
    rise_o <= rise_i;
    fall_o <= fall_i;
  end
endmodule

// [input_ddr_capture_tb.sv]
// Testbench for the dual edge capture block, with a fabric-side sink.
// Assumes the APB timing and configuration layout of the design package.
`timescale 1ns/1ps
module input_ddr_capture_tb;
  import dec_pkg::*;
  localparam logic [15:0] PR = 16'hB4E1;
  localparam logic [15:0] PF = 16'h6A39;
  logic        CLK_I = 0, SYS_RST_I = 1, PSEL_I = 0, PENABLE_I = 0, PWRITE_I = 0;
  logic [7:0]  PADDR_I = 0;
  logic [31:0] PWDATA_I = 0, PRDATA_O;
  logic        PREADY_O, PSLVERR_O, DATA_I = 0, CE_I = 1, SR_I = 0, REV_I = 0;
  logic        RISE_O, FALL_O, COMB_O, rise_seen, fall_seen;
  int          error_cnt = 0;
  int          check_count = 0;

  always #50 CLK_I = ~CLK_I;

  dec_capture dut_u (.CLK_I(CLK_I), .SYS_RST_I(SYS_RST_I), .PSEL_I(PSEL_I),
    .PENABLE_I(PENABLE_I), .PWRITE_I(PWRITE_I), .PADDR_I(PADDR_I), .PWDATA_I(PWDATA_I),
    .PRDATA_O(PRDATA_O), .PREADY_O(PREADY_O), .PSLVERR_O(PSLVERR_O), .DATA_I(DATA_I),
    .CE_I(CE_I), .SR_I(SR_I), .REV_I(REV_I), .RISE_O(RISE_O), .FALL_O(FALL_O),
    .COMB_O(COMB_O));
  dec_sink sink_u (.clk_i(CLK_I), .rise_i(RISE_O), .fall_i(FALL_O),
    .rise_o(rise_seen), .fall_o(fall_seen));

  task stop_test;
    $display("checks %0d mismatches %0d", check_count, error_cnt);
    if (error_cnt == 0 && check_count > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask

  task chk(input logic [31:0] got, input logic [31:0] exp);
    check_count++;
    if (got !== exp) begin
      error_cnt++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task apb(input logic w, input logic [7:0] a, input logic [31:0] d,
           output logic [31:0] q, output logic e);
    int n;
    @(posedge CLK_I);
    PSEL_I   <= 1;
    PWRITE_I <= w;
    PADDR_I  <= a;
    PWDATA_I <= d;
    @(posedge CLK_I);
    PENABLE_I <= 1;
    n = 0;
    // Ready and the answer stand for the whole access cycle, so they are
    // looked at mid-cycle and the transfer completes at the next rising edge.
    @(negedge CLK_I);
    while (PREADY_O !== 1'b1 && n < 20) begin
      @(negedge CLK_I);
      n++;
    end
    if (n >= 20) begin
      error_cnt++;
      stop_test();
    end
    q = PRDATA_O;
    e = PSLVERR_O;
    @(posedge CLK_I);
    PSEL_I    <= 0;
    PENABLE_I <= 0;
  endtask

  // One bit period: the rising sample settles before the rising edge,
  // the falling sample before the falling edge.
  task cyc(input logic r, input logic f);
    @(negedge CLK_I);
    DATA_I <= r;
    @(posedge CLK_I);
    DATA_I <= f;
    #1;
  endtask

  task frc(input logic s, input logic v);
    @(negedge CLK_I);
    SR_I  <= s;
    REV_I <= v;
  endtask

  task t_regs;
    logic [31:0] q;
    logic        e;
    apb(0, DEC_CFG_ADDR, 0, q, e);
    chk(q, 32'h0000_2000);
    apb(0, DEC_STAT_ADDR, 0, q, e);
    chk(q, 32'h0000_0020);
    apb(0, 8'h08, 0, q, e);
    chk({q[30:0], e}, 32'h0000_0001);
    $display("test regs done");
  endtask

  task t_modes;
    logic [31:0] q;
    logic        e;
    for (int m = 0; m < 4; m++) begin
      apb(1, DEC_CFG_ADDR, 32'h0000_2000 | m, q, e);
      for (int k = 0; k < 12; k++) begin
        cyc(PR[k], PF[k]);
        chk(COMB_O, PF[k]);
        if (k >= 3) begin
          chk(rise_seen, (m == 2) ? PR[k-2] : PR[k-1]);
          chk(fall_seen, (m == 1 || m == 2) ? PF[k-2] : PF[k-1]);
        end
      end
    end
    $display("test modes done");
  endtask

  task t_force;
    logic [31:0] q;
    logic [1:0]  p;
    logic        e, sv, er;
    for (int i = 0; i < 6; i++) begin
      p  = 2'(i % 3 + 1);
      sv = (i > 2);
      e  = (p == 2'b11) ? 1'b0 : (p[1] ? sv : ~sv);
      apb(1, DEC_CFG_ADDR, 32'h0000_2000 | {27'h0, sv, sv, 3'h0}, q, er);
      frc(0, 0);
      cyc(~e, ~e);
      cyc(~e, ~e);
      frc(p[1], p[0]);
      @(posedge CLK_I);
      #1;
      chk({RISE_O, FALL_O}, {e, ~e});
      @(negedge CLK_I);
      #1;
      chk({RISE_O, FALL_O}, {e, e});
    end
    frc(0, 0);
    $display("test force done");
  endtask

  task t_enable;
    logic [31:0] q;
    logic        e;
    apb(1, DEC_CFG_ADDR, 32'h0000_2000, q, e);
    cyc(1, 1);
    cyc(1, 1);
    CE_I <= 0;
    frc(1, 0);
    cyc(0, 0);
    cyc(0, 0);
    chk({RISE_O, FALL_O}, 2'b11);
    apb(1, DEC_CFG_ADDR, 32'h0000_2004, q, e);
    @(posedge CLK_I);
    @(negedge CLK_I);
    #1;
    chk({RISE_O, FALL_O}, 2'b00);
    frc(0, 0);
    apb(1, DEC_CFG_ADDR, 32'h0000_2400, q, e);
    cyc(1, 1);
    cyc(1, 1);
    cyc(1, 1);
    chk({RISE_O, FALL_O}, 2'b11);
    apb(1, DEC_CFG_ADDR, 32'h0000_2080, q, e);
    cyc(0, 1);
    cyc(0, 1);
    cyc(0, 1);
    chk({RISE_O, FALL_O}, 2'b11);
    apb(1, DEC_CFG_ADDR, 32'h0000_0000, q, e);
    cyc(0, 0);
    cyc(0, 0);
    cyc(0, 0);
    chk({RISE_O, FALL_O}, 2'b00);
    $display("test enable done");
  endtask

  initial begin
    repeat (12) @(posedge CLK_I);
    SYS_RST_I <= 0;
    repeat (2) @(posedge CLK_I);
    t_regs();
    t_modes();
    t_force();
    t_enable();
    stop_test();
  end
endmodule
